// >>> rtl/ptpc_panel_timing.sv
// Panel timing generator with portrait rotation and AXI4-Lite registers
// What this block does
// - Mode register bit 7 set turns portrait rotation on; clear means normal orientation.
// - Portrait shows the frame buffer turned 90 degrees counterclockwise, done in hardware.
// - Rotation works only at 16 and 8 bits per pixel.
// - Cursor and ink overlay stay unrotated while portrait is on.
// - Portrait is capped at a line total (display plus blank) of 1024 shifts and at 1024 display lines.
// - Horizontal display lasts (field 6:0 plus one) times 8 shift clocks.
// - Horizontal blank lasts (field 4:0 plus one) times 8 shift clocks.
// - Vertical display lines are one plus the 10-bit vertical display field.
// - Vertical blank lines are field 5:0 plus one.
// - Line is display plus blank shifts; frame is display plus blank lines.
// - Pixel clock derives from the source clock by divider bits 2:1.
// - Shift clock to pixel clock ratio follows the panel type register.
// - Display FIFO register bit 7 stops display fetch while set.
// - External clock mode takes memory clock from the external source.
// - Mode register bit 0 enables panel output and starts power-on.
`include "ptpc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module ptpc_panel_timing (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output logic                      pclk_tick,
  output logic                      shift_tick,
  output logic                      h_active,
  output logic                      v_active,
  output logic                      line_start,
  output logic                      frame_start,
  output logic                      fetch_req,
  output ptpc_pkg::ptpc_addr_t      fetch_addr,
  output ptpc_pkg::ptpc_cnt_t       overlay_x,
  output ptpc_pkg::ptpc_cnt_t       overlay_y,
  output logic                      portrait_active,
  output logic                      panel_output_enable,
  output logic                      crt_output_enable,
  output logic                      power_on_start,
  output logic                      mclk_from_ext
);
  import ptpc_pkg::*;

  // Register store, one byte per index
  ptpc_byte_t regs_q [0:63];
  logic       aw_have_q;
  logic       w_have_q;
  logic [5:0] aw_idx_q;
  ptpc_byte_t w_data_q;
  logic       w_lane_q;
  logic       bvalid_q;
  logic [1:0] bresp_q;
  logic       rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // Index decode of mapped registers
  function automatic logic idx_mapped(input logic [5:0] idx);
    unique case (idx)
      `PTPC_IDX_PANEL_TYPE, `PTPC_IDX_HDISP, `PTPC_IDX_HBLANK, `PTPC_IDX_VDISP_LO,
      `PTPC_IDX_VDISP_HI, `PTPC_IDX_VBLANK, `PTPC_IDX_MODE, `PTPC_IDX_S1_LO,
      `PTPC_IDX_S1_MID, `PTPC_IDX_S1_HI, `PTPC_IDX_S2_LO, `PTPC_IDX_S2_MID,
      `PTPC_IDX_S2_HI, `PTPC_IDX_OFS_LO, `PTPC_IDX_OFS_HI, `PTPC_IDX_CLKDIV,
      `PTPC_IDX_HALF_FRAME, `PTPC_IDX_FIFO, `PTPC_IDX_CLK_SRC, `PTPC_IDX_STATUS: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : idx_mapped

  // Write channel handshakes; address and data taken in either order
  wire        aw_take   = s_axi_awvalid && s_axi_awready;
  wire        w_take    = s_axi_wvalid && s_axi_wready;
  wire        aw_ready_now = aw_have_q || aw_take;
  wire        w_ready_now  = w_have_q || w_take;
  wire        do_write  = aw_ready_now && w_ready_now && !bvalid_q;
  wire [5:0]  wr_idx    = aw_have_q ? aw_idx_q : s_axi_awaddr[7:2];
  wire [7:0]  wr_data   = w_have_q ? w_data_q : s_axi_wdata[7:0];
  wire        wr_lane   = w_have_q ? w_lane_q : s_axi_wstrb[0];
  // Status is read-only, so a write there is refused like an unmapped one
  wire        wr_ok     = idx_mapped(wr_idx) && (wr_idx != `PTPC_IDX_STATUS);
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready  = !w_have_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  // Read channel; one read in flight
  wire        ar_take   = s_axi_arvalid && s_axi_arready;
  wire [5:0]  rd_idx    = s_axi_araddr[7:2];
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // Field extraction
  wire [7:0]  pt_reg      = regs_q[`PTPC_IDX_PANEL_TYPE];
  wire [7:0]  mode_reg    = regs_q[`PTPC_IDX_MODE];
  wire [6:0]  hdisp_f     = regs_q[`PTPC_IDX_HDISP][6:0];
  wire [4:0]  hblank_f    = regs_q[`PTPC_IDX_HBLANK][4:0];
  wire [9:0]  vdisp_f     = {regs_q[`PTPC_IDX_VDISP_HI][1:0], regs_q[`PTPC_IDX_VDISP_LO]};
  wire [5:0]  vblank_f    = regs_q[`PTPC_IDX_VBLANK][5:0];
  wire [1:0]  pdiv_f      = regs_q[`PTPC_IDX_CLKDIV][2:1];
  wire [2:0]  bpp_f       = mode_reg[4:2];
  wire [10:0] ofs_words   = {regs_q[`PTPC_IDX_OFS_HI][2:0], regs_q[`PTPC_IDX_OFS_LO]};
  wire [23:0] start_words = {regs_q[`PTPC_IDX_S1_HI], regs_q[`PTPC_IDX_S1_MID], regs_q[`PTPC_IDX_S1_LO]};
  wire        fifo_off    = regs_q[`PTPC_IDX_FIFO][`PTPC_FIFO_DISABLE];
  wire        disp_on     = mode_reg[`PTPC_MODE_PANEL_EN] || mode_reg[`PTPC_MODE_CRT_EN];

  // Period lengths; widened so the sums cannot overflow
  wire [10:0] hdp_shifts  = {({1'b0, hdisp_f} + 8'h01), 3'h0};
  wire [10:0] hb_shifts   = {({3'h0, hblank_f} + 8'h01), 3'h0};
  wire [10:0] h_total     = hdp_shifts + hb_shifts;
  wire [10:0] vdp_lines   = {1'b0, vdisp_f} + 11'h1;
  wire [10:0] vb_lines    = {5'h0, vblank_f} + 11'h1;
  wire [10:0] v_total     = vdp_lines + vb_lines;

  // Pixel clock divider: 1, 2, 3 or 4 source cycles
  wire [2:0]  pdiv_len    = {1'b0, pdiv_f} + 3'h1;

  // Shift clock ratio from the panel type
  function automatic logic [3:0] shift_ratio(input logic [7:0] pt);
    logic [1:0] width;
    width = pt[5:4];
    if (pt[`PTPC_PT_TFT]) return 4'h1;
    if (!pt[`PTPC_PT_COLOR]) begin
      if (pt[`PTPC_PT_DUAL] || width == 2'h0) return 4'h4;
      return 4'h8;
    end
    if (pt[`PTPC_PT_DUAL]) return (width == 2'h0) ? 4'h1 : 4'h2;
    unique case (width)
      2'h0:    return 4'h1;
      2'h1:    return pt[`PTPC_PT_TYPE2] ? 4'h2 : 4'h4;
      default: return 4'h5;
    endcase
  endfunction : shift_ratio
  wire [3:0]  sratio = shift_ratio(pt_reg);

  logic [2:0] pdiv_cnt_q;
  logic [3:0] sdiv_cnt_q;
  ptpc_cnt_t  h_cnt_q;
  ptpc_cnt_t  v_cnt_q;

  // Divider terminal counts use >= so a smaller ratio written mid-count acts at once, not after a wrap
  assign pclk_tick  = disp_on && (pdiv_cnt_q >= pdiv_len - 3'h1);
  assign shift_tick = pclk_tick && (sdiv_cnt_q >= sratio - 4'h1);
  wire   h_wrap     = shift_tick && (h_cnt_q == h_total - 11'h1);
  wire   v_wrap     = h_wrap && (v_cnt_q == v_total - 11'h1);
  assign h_active   = disp_on && (h_cnt_q < hdp_shifts);
  assign v_active   = disp_on && (v_cnt_q < vdp_lines);
  assign line_start = h_wrap;
  assign frame_start = v_wrap;

  // Clock dividers run only while a display is enabled
  always_ff @(posedge aclk) begin
    if (!aresetn || !disp_on) begin
      pdiv_cnt_q <= 3'h0;
      sdiv_cnt_q <= 4'h0;
    end else if (pclk_tick) begin
      pdiv_cnt_q <= 3'h0;
      sdiv_cnt_q <= shift_tick ? 4'h0 : sdiv_cnt_q + 4'h1;
    end else begin
      pdiv_cnt_q <= pdiv_cnt_q + 3'h1;
    end
  end

  // Shift and line counters restart after the blank period
  always_ff @(posedge aclk) begin
    if (!aresetn || !disp_on) begin
      h_cnt_q <= 11'h0;
      v_cnt_q <= 11'h0;
    end else if (shift_tick) begin
      h_cnt_q <= h_wrap ? 11'h0 : h_cnt_q + 11'h1;
      if (h_wrap) v_cnt_q <= v_wrap ? 11'h0 : v_cnt_q + 11'h1;
    end
  end

  // Portrait allowed only at 8 and 16 bpp and within the 1024 square
  wire bpp_rotatable = (bpp_f == `PTPC_BPP_16) || (bpp_f == `PTPC_BPP_8);
  wire fits_square   = (h_total <= `PTPC_PORTRAIT_MAX) && (vdp_lines <= `PTPC_PORTRAIT_MAX);
  assign portrait_active = mode_reg[`PTPC_MODE_PORTRAIT] && bpp_rotatable && fits_square;

  // Pixel position of the current shift within the visible area
  wire [10:0] disp_x = h_cnt_q;
  wire [10:0] disp_y = v_cnt_q;
  // Cursor and ink overlay always get raw coordinates
  assign overlay_x = disp_x;
  assign overlay_y = disp_y;

  // Normal fetch: start + row * offset + column in words
  wire        is16    = (bpp_f == `PTPC_BPP_16);
  wire [23:0] row_ofs = 24'(disp_y) * 24'(ofs_words);
  wire [23:0] col_wd  = is16 ? 24'(disp_x) : 24'(disp_x >> 1);
  wire [23:0] norm_addr = start_words + row_ofs + col_wd;
  // Portrait: a displayed row walks a stored column, read top down, last column first, giving a counterclockwise turn
  wire [10:0] src_col = vdp_lines - 11'h1 - disp_y;
  wire [23:0] rot_row = 24'(disp_x) * 24'(ofs_words);
  wire [23:0] rot_col = is16 ? 24'(src_col) : 24'(src_col >> 1);
  wire [23:0] rot_addr = start_words + rot_row + rot_col;
  wire        fetch_now = h_active && v_active && !fifo_off;

  ptpc_addr_t fetch_addr_q;
  logic       fetch_req_q;
  // Registered fetch request and address, one cycle behind position
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fetch_req_q  <= 1'b0;
      fetch_addr_q <= 24'h0;
    end else begin
      fetch_req_q  <= fetch_now && shift_tick;
      fetch_addr_q <= portrait_active ? rot_addr : norm_addr;
    end
  end
  assign fetch_req  = fetch_req_q;
  assign fetch_addr = fetch_addr_q;

  // Output enables and clock source select
  assign panel_output_enable = mode_reg[`PTPC_MODE_PANEL_EN];
  assign crt_output_enable   = mode_reg[`PTPC_MODE_CRT_EN];
  assign mclk_from_ext       = regs_q[`PTPC_IDX_CLK_SRC][`PTPC_CLKSRC_EXT];

  // Panel power state; a fresh enable launches the power-on sequence once
  ptpc_pwr_e pwr_q;
  logic      pwr_start_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwr_q       <= PTPC_PWR_OFF;
      pwr_start_q <= 1'b0;
    end else begin
      pwr_start_q <= 1'b0;
      unique case (pwr_q)
        PTPC_PWR_OFF: if (panel_output_enable) begin
          pwr_q       <= PTPC_PWR_ON;
          pwr_start_q <= 1'b1;
        end
        PTPC_PWR_ON: if (!panel_output_enable) pwr_q <= PTPC_PWR_OFF;
      endcase
    end
  end
  assign power_on_start = pwr_start_q;

  // Status byte shows live timing state
  wire [7:0] status_byte = {4'h0, pwr_q == PTPC_PWR_ON, portrait_active, v_active, h_active};
  wire [7:0] rd_byte = (rd_idx == `PTPC_IDX_STATUS) ? status_byte : regs_q[rd_idx];

  // Register writes; only byte lane 0 carries data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 64; i++) regs_q[i] <= `PTPC_REG_RESET;
    end else if (do_write && wr_ok && wr_lane) begin
      regs_q[wr_idx] <= wr_data;
    end
  end

  // Write channel holding and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_idx_q  <= 6'h0;
      w_data_q  <= 8'h00;
      w_lane_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'h0;
    end else begin
      if (aw_take) aw_idx_q <= s_axi_awaddr[7:2];
      if (w_take) begin
        w_data_q <= s_axi_wdata[7:0];
        w_lane_q <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_ok ? 2'h0 : 2'h2;
      end else begin
        if (aw_take) aw_have_q <= 1'b1;
        if (w_take)  w_have_q  <= 1'b1;
        if (bvalid_q && s_axi_bready) bvalid_q <= 1'b0;
      end
    end
  end

  // Read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0;
      rresp_q  <= 2'h0;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q  <= idx_mapped(rd_idx) ? {24'h0, rd_byte} : 32'h0;
      rresp_q  <= idx_mapped(rd_idx) ? 2'h0 : 2'h2;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence line_end_s;
    shift_tick && (h_cnt_q == h_total - 11'h1);
  endsequence
  sequence line_restart_s;
    h_cnt_q == 11'h0;
  endsequence

  line_wrap_a: assert property (line_end_s |=> line_restart_s)
    else $error("line counter did not restart");
  line_pulse_a: assert property (line_start == (shift_tick && h_cnt_q == h_total - 11'h1))
    else $error("line start not at line end");
  frame_pulse_a: assert property (frame_start |-> line_start && v_cnt_q == v_total - 11'h1)
    else $error("frame start not at last line");
  hdisp_len_a: assert property (h_active |-> h_cnt_q < ({4'h0, hdisp_f} + 11'h1) * 11'h8)
    else $error("horizontal display too long");
  hblank_len_a: assert property (h_total == ({4'h0, hdisp_f} + {6'h0, hblank_f} + 11'h2) * 11'h8)
    else $error("line total wrong");
  vdisp_len_a: assert property (disp_on && v_cnt_q == {1'b0, vdisp_f} |-> v_active)
    else $error("last display line missing");
  vblank_len_a: assert property (v_total == {1'b0, vdisp_f} + {5'h0, vblank_f} + 11'h2)
    else $error("frame total wrong");
  pclk_div2_a: assert property (pdiv_f == 2'h1 && $past(pdiv_f) == 2'h1 && $past(pdiv_f, 2) == 2'h1 &&
    disp_on && $past(disp_on) && $past(pclk_tick, 2) |-> !$past(pclk_tick) && pclk_tick)
    else $error("pixel divider by two wrong");
  tft_ratio_a: assert property (pt_reg[`PTPC_PT_TFT] |-> shift_tick == pclk_tick)
    else $error("panel shift ratio wrong");
  portrait_bpp_a: assert property (portrait_active |-> bpp_rotatable && mode_reg[`PTPC_MODE_PORTRAIT])
    else $error("rotation at unsupported depth");
  portrait_cap_a: assert property (portrait_active |-> vdp_lines <= `PTPC_PORTRAIT_MAX)
    else $error("rotated surface too large");
  rot_addr_a: assert property (portrait_active && $stable(portrait_active) |-> fetch_addr_q == $past(rot_addr))
    else $error("portrait address not rotated");
  overlay_raw_a: assert property (overlay_x == h_cnt_q && overlay_y == v_cnt_q)
    else $error("overlay coordinates rotated");
  fifo_stop_a: assert property (fifo_off && $past(fifo_off) |-> !fetch_req)
    else $error("fetch while fifo disabled");
  power_start_a: assert property ($rose(panel_output_enable) |=> power_on_start ##1 !power_on_start)
    else $error("power-on sequence not started");
  clk_src_a: assert property (mclk_from_ext == regs_q[`PTPC_IDX_CLK_SRC][0])
    else $error("memory clock source select wrong");
  write_resp_a: assert property (do_write |=> s_axi_bvalid)
    else $error("write response missing");
  read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response missing");
  // Ratio spot checks against fixed table values, not the decode function
  mono4_ratio_a: assert property (pt_reg[2:0] == 3'h0 && pt_reg[5:4] == 2'h0 |-> sratio == 4'h4)
    else $error("mono 4-bit ratio wrong");
  color16_ratio_a: assert property (pt_reg[2:0] == 3'h4 && pt_reg[5:4] == 2'h2 |-> sratio == 4'h5)
    else $error("colour 16-bit ratio wrong");
  portrait_width_a: assert property (portrait_active |-> h_total <= `PTPC_PORTRAIT_MAX)
    else $error("rotated line too long");
  panel_idle_a: assert property (!panel_output_enable |=> !power_on_start)
    else $error("power-on without panel enable");
endmodule : ptpc_panel_timing
`default_nettype wire

// >>> rtl/ptpc_consts.svh
// Offsets, field positions and reset values of the panel timing block
`ifndef PTPC_CONSTS_SVH
`define PTPC_CONSTS_SVH
// Register indices; byte address is four times the index
`define PTPC_IDX_PANEL_TYPE   6'h02
`define PTPC_IDX_HDISP        6'h04
`define PTPC_IDX_HBLANK       6'h05
`define PTPC_IDX_VDISP_LO     6'h08
`define PTPC_IDX_VDISP_HI     6'h09
`define PTPC_IDX_VBLANK       6'h0a
`define PTPC_IDX_MODE         6'h0d
`define PTPC_IDX_S1_LO        6'h10
`define PTPC_IDX_S1_MID       6'h11
`define PTPC_IDX_S1_HI        6'h12
`define PTPC_IDX_S2_LO        6'h13
`define PTPC_IDX_S2_MID       6'h14
`define PTPC_IDX_S2_HI        6'h15
`define PTPC_IDX_OFS_LO       6'h16
`define PTPC_IDX_OFS_HI       6'h17
`define PTPC_IDX_CLKDIV       6'h19
`define PTPC_IDX_HALF_FRAME   6'h1b
`define PTPC_IDX_FIFO         6'h23
`define PTPC_IDX_CLK_SRC      6'h24
`define PTPC_IDX_STATUS       6'h3c
// Field positions
`define PTPC_MODE_PANEL_EN    0
`define PTPC_MODE_CRT_EN      1
`define PTPC_MODE_PORTRAIT    7
`define PTPC_FIFO_DISABLE     7
`define PTPC_CLKSRC_EXT       0
`define PTPC_PT_TFT           0
`define PTPC_PT_DUAL          1
`define PTPC_PT_COLOR         2
`define PTPC_PT_TYPE2         6
// Colour depth codes in mode bits 4:2
`define PTPC_BPP_8            3'h3
`define PTPC_BPP_16           3'h5
// Geometry
`define PTPC_SHIFTS_PER_UNIT  4'h8
`define PTPC_PORTRAIT_MAX     11'h400
`define PTPC_REG_RESET        8'h00
`endif

// >>> rtl/ptpc_pkg.sv
// Types shared by the panel timing block
package ptpc_pkg;
  typedef enum logic [0:0] {PTPC_PWR_OFF, PTPC_PWR_ON} ptpc_pwr_e;
  typedef logic [7:0]  ptpc_byte_t;
  typedef logic [10:0] ptpc_cnt_t;
  typedef logic [23:0] ptpc_addr_t;
endpackage : ptpc_pkg

// >>> testbench/ptpc_panel_model.sv
// Passive panel model that measures line and frame geometry
`timescale 1ns/1ps
`default_nettype none
module ptpc_panel_model (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 shift_tick,
  input  wire logic                 h_active,
  input  wire logic                 v_active,
  input  wire logic                 line_start,
  input  wire logic                 frame_start,
  input  wire logic                 fetch_req,
  input  wire ptpc_pkg::ptpc_addr_t fetch_addr,
  input  wire ptpc_pkg::ptpc_cnt_t  overlay_x,
  input  wire ptpc_pkg::ptpc_cnt_t  overlay_y,
  input  wire logic                 power_on_start,
  output logic [15:0]               gap_q,
  output logic [15:0]               line_len_q,
  output logic [15:0]               hact_len_q,
  output logic [15:0]               frame_len_q,
  output logic [15:0]               vact_len_q,
  output logic [15:0]               fetches_q,
  output ptpc_pkg::ptpc_addr_t      first_addr_q,
  output ptpc_pkg::ptpc_cnt_t       ox_q,
  output ptpc_pkg::ptpc_cnt_t       oy_q,
  output logic [15:0]               pwr_q
);
  import ptpc_pkg::*;
  logic [15:0] cyc_q, sh_q, ha_q, ln_q, va_q, fc_q;
  logic        armed_q;
  // A panel only listens; it latches line and frame counts at their boundaries and the shift gap at each shift
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {cyc_q, sh_q, ha_q, ln_q, va_q, fc_q, gap_q, line_len_q, hact_len_q} <= '0;
      {frame_len_q, vact_len_q, fetches_q, pwr_q, first_addr_q, ox_q, oy_q, armed_q} <= '0;
    end else begin
      cyc_q <= shift_tick ? 16'h0001 : cyc_q + 16'h0001;
      if (shift_tick) gap_q <= cyc_q;
      sh_q <= line_start ? 16'h0000 : sh_q + {15'h0, shift_tick};
      ha_q <= line_start ? 16'h0000 : ha_q + {15'h0, shift_tick & h_active};
      if (line_start) line_len_q <= sh_q + 16'h0001;
      if (line_start) hact_len_q <= ha_q;
      ln_q <= frame_start ? 16'h0000 : ln_q + {15'h0, line_start};
      va_q <= frame_start ? 16'h0000 : va_q + {15'h0, line_start & v_active};
      fc_q <= frame_start ? 16'h0000 : fc_q + {15'h0, fetch_req};
      pwr_q <= pwr_q + {15'h0, power_on_start};
      if (frame_start) begin
        frame_len_q <= ln_q + 16'h0001;
        vact_len_q  <= va_q;
        fetches_q   <= fc_q;
        ox_q        <= overlay_x;
        oy_q        <= overlay_y;
        armed_q     <= 1'b1;
      end else if (fetch_req && armed_q) begin
        first_addr_q <= fetch_addr;
        armed_q      <= 1'b0;
      end
    end
  end
endmodule : ptpc_panel_model
`default_nettype wire

// >>> testbench/ptpc_panel_timing_bench.sv
// Self-checking bench for the panel timing block
`timescale 1ns/1ps
`default_nettype none
`include "ptpc_consts.svh"
module ptpc_panel_timing_bench;
  import ptpc_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        pclk_tick, shift_tick, h_active, v_active, line_start, frame_start, fetch_req;
  logic        portrait_active, panel_output_enable, crt_output_enable, power_on_start, mclk_from_ext;
  ptpc_addr_t  fetch_addr, first_addr;
  ptpc_cnt_t   overlay_x, overlay_y, ox, oy;
  logic [15:0] gap, line_len, hact_len, frame_len, vact_len, fetches, pwr_cnt;
  int          err_total, checks_done;

  ptpc_panel_timing dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pclk_tick(pclk_tick),
    .shift_tick(shift_tick), .h_active(h_active), .v_active(v_active), .line_start(line_start),
    .frame_start(frame_start), .fetch_req(fetch_req), .fetch_addr(fetch_addr), .overlay_x(overlay_x),
    .overlay_y(overlay_y), .portrait_active(portrait_active), .panel_output_enable(panel_output_enable),
    .crt_output_enable(crt_output_enable), .power_on_start(power_on_start), .mclk_from_ext(mclk_from_ext));

  ptpc_panel_model panel (.aclk(aclk), .aresetn(aresetn), .shift_tick(shift_tick), .h_active(h_active),
    .v_active(v_active), .line_start(line_start), .frame_start(frame_start), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .overlay_x(overlay_x), .overlay_y(overlay_y), .power_on_start(power_on_start),
    .gap_q(gap), .line_len_q(line_len), .hact_len_q(hact_len), .frame_len_q(frame_len),
    .vact_len_q(vact_len), .fetches_q(fetches), .first_addr_q(first_addr), .ox_q(ox), .oy_q(oy),
    .pwr_q(pwr_cnt));

  // 50 MHz clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  // One write; address and data offered together, each released when taken
  task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    check({30'h0, bresp}, {30'h0, er}, "write response");
  endtask : wr

  task automatic rd(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er);
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    check({30'h0, rresp}, {30'h0, er}, "read response");
    check(rdata, {24'h000000, d}, "read data");
  endtask : rd

  // Bounded wait for whole frames, then let the model latch
  task automatic wait_frames(input int nf);
    int k, c;
    k = 0;
    c = 0;
    while (k < nf && c < 60000) begin
      @(posedge aclk);
      c++;
      if (frame_start === 1'b1) k++;
    end
    check(c < 60000, 1'b1, "frame wait");
    @(posedge aclk);
    #1;
  endtask : wait_frames

  task automatic t_regs;
    rd(`PTPC_IDX_MODE, 8'h00, 2'b00);
    rd(6'h3f, 8'h00, 2'b10);
    wr(6'h3f, 8'h5a, 2'b10);
    wr(`PTPC_IDX_STATUS, 8'hff, 2'b10);
    wr(`PTPC_IDX_HDISP, 8'h5a, 2'b00);
    rd(`PTPC_IDX_HDISP, 8'h5a, 2'b00);
  endtask : t_regs

  task automatic t_timing;
    wr(`PTPC_IDX_PANEL_TYPE, 8'h01, 2'b00);
    wr(`PTPC_IDX_HDISP, 8'h00, 2'b00);
    wr(`PTPC_IDX_HBLANK, 8'h01, 2'b00);
    wr(`PTPC_IDX_VDISP_LO, 8'h00, 2'b00);
    wr(`PTPC_IDX_VDISP_HI, 8'h01, 2'b00);
    wr(`PTPC_IDX_VBLANK, 8'h02, 2'b00);
    wr(`PTPC_IDX_CLKDIV, 8'h02, 2'b00);
    wr(`PTPC_IDX_S1_MID, 8'h03, 2'b00);
    wr(`PTPC_IDX_MODE, 8'h15, 2'b00);
    wait_frames(2);
    check(gap, 16'd2, "shift spacing");
    check(line_len, 16'd24, "line length");
    check(hact_len, 16'd8, "display shifts");
    check(line_len - hact_len, 16'd16, "blank shifts");
    check(vact_len, 16'd257, "display lines");
    check(frame_len, 16'd260, "frame lines");
    check(first_addr, 24'h000300, "normal start");
    check(fetches, 16'd2056, "fetches per frame");
    check(pwr_cnt, 16'd1, "power start");
    check({panel_output_enable, crt_output_enable}, 2'b10, "outputs");
  endtask : t_timing

  task automatic t_ratio;
    logic [7:0] pt [3];
    logic [15:0] g [3];
    pt = '{8'h00, 8'h24, 8'h01};
    g = '{16'd4, 16'd5, 16'd1};
    wr(`PTPC_IDX_CLKDIV, 8'h00, 2'b00);
    for (int i = 0; i < 3; i++) begin
      wr(`PTPC_IDX_PANEL_TYPE, pt[i], 2'b00);
      repeat (40) @(posedge aclk);
      #1;
      check(gap, g[i], "shift ratio");
    end
  endtask : t_ratio

  task automatic t_portrait;
    wr(`PTPC_IDX_OFS_LO, 8'h00, 2'b00);
    wr(`PTPC_IDX_OFS_HI, 8'h04, 2'b00);
    wr(`PTPC_IDX_S1_LO, 8'hf8, 2'b00);
    wr(`PTPC_IDX_MODE, 8'h95, 2'b00);
    wait_frames(2);
    check(portrait_active, 1'b1, "portrait on");
    check(first_addr, 24'h0004f8, "rotated start");
    check({ox, oy}, {11'd23, 11'd259}, "overlay raw");
    wr(`PTPC_IDX_MODE, 8'h89, 2'b00);
    check(portrait_active, 1'b0, "low depth");
    wr(`PTPC_IDX_MODE, 8'h8d, 2'b00);
    check(portrait_active, 1'b1, "8 bpp");
    wr(`PTPC_IDX_MODE, 8'h15, 2'b00);
    check(portrait_active, 1'b0, "portrait off");
    wr(`PTPC_IDX_MODE, 8'h95, 2'b00);
    wr(`PTPC_IDX_HBLANK, 8'h00, 2'b00);
    wr(`PTPC_IDX_HDISP, 8'h7e, 2'b00);
    check(portrait_active, 1'b1, "cap edge");
    wr(`PTPC_IDX_HDISP, 8'h7f, 2'b00);
    check(portrait_active, 1'b0, "over cap");
    wr(`PTPC_IDX_HDISP, 8'h00, 2'b00);
    wr(`PTPC_IDX_HBLANK, 8'h01, 2'b00);
  endtask : t_portrait

  task automatic t_fifo_clk;
    wr(`PTPC_IDX_FIFO, 8'h80, 2'b00);
    wait_frames(2);
    check(fetches, 16'd0, "fetch stopped");
    wr(`PTPC_IDX_FIFO, 8'h00, 2'b00);
    wait_frames(2);
    check(fetches, 16'd2056, "fetch resumed");
    wr(`PTPC_IDX_CLK_SRC, 8'h01, 2'b00);
    check(mclk_from_ext, 1'b1, "external clock");
    rd(`PTPC_IDX_CLK_SRC, 8'h01, 2'b00);
  endtask : t_fifo_clk

  // Main sequence; reset held three cycles
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'h1;
    err_total = 0;
    checks_done = 0;
    aresetn = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_timing();
    t_ratio();
    t_portrait();
    t_fifo_clk();
    report_and_stop();
  end

  // Watchdog well beyond the expected run
  initial begin
    repeat (90000) @(posedge aclk);
    err_total++;
    report_and_stop();
  end
endmodule : ptpc_panel_timing_bench
`default_nettype wire
